/* mbs_barrier_sync.sv */
// Memory barrier and instruction-cache line synchronisation
// How it works
// - A load counts done only when its value is fixed for all storers.
// - A store counts done only when every loader would see it.
// - In strongly ordered systems the barrier completes at once, no error.
// - Barrier splits accesses; earlier group visible before any later.
// - Mixed memory types on one location stay unpredictable; no fix.
// - Barrier effect on write buffers, maintenance accesses undefined.
// - Prefetches are not ordered around the barrier.
// - Line sync runs in every mode, no privilege check.
// - Address is sign-extended 16-bit offset plus base.
// - Line sync acts only on the one line holding the address.
// - Only load-cause translation faults; never store cause or modified.
// - Writeback cache or bus error: cache error; bus fault: bus error.
// - Faulting kernel address may give load address error.
// - Watch match on line sync follows one fixed choice.
// - Locked lines are left untouched.
// - Only local caches are acted on, shared levels as needed.
// - First-release cores raise reserved instruction for line sync.
// - Type zero: earlier accesses globally performed before later ones.
// - Only uncached or cached coherent shared accesses synchronize.
`timescale 1ns/100ps
module mbs_barrier_sync (
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_reset_n,
    // Instruction issue
    input  wire logic                      i_op_valid,
    input  wire mbs_pkg::mbs_op_t          i_op_kind,
    input  wire logic [mbs_pkg::STYPE_W-1:0] i_stype,
    input  wire logic [mbs_pkg::ADDR_W-1:0]  i_base,
    input  wire logic [mbs_pkg::OFF_W-1:0]   i_offset,
    input  wire logic                      i_arch_rel1,
    input  wire logic                      i_strong_order,
    output logic                           o_op_ready,
    output logic                           o_op_done,
    output logic                           o_exc_valid,
    output logic [mbs_pkg::EXC_W-1:0]      o_exc_code,
    output logic                           o_cache_err,
    // Memory access tracking
    input  wire logic                      i_mem_issue,
    input  wire logic [mbs_pkg::CCA_W-1:0] i_mem_cca,
    input  wire logic                      i_mem_prefetch,
    input  wire logic                      i_mem_gperf,
    output logic                           o_mem_hold,
    // Address translation
    output logic                           o_xlat_req,
    output logic [mbs_pkg::ADDR_W-1:0]     o_xlat_va,
    input  wire logic                      i_xlat_ack,
    input  wire logic                      i_xlat_refill,
    input  wire logic                      i_xlat_invalid,
    input  wire logic                      i_xlat_kfault,
    // Cache line operation
    output logic                           o_line_req,
    output logic [mbs_pkg::ADDR_W-1:0]     o_line_addr,
    output logic                           o_line_spare_locked,
    input  wire logic                      i_line_ack,
    input  wire logic                      i_line_err,
    input  wire logic                      i_line_bus_err,
    // Watch and hazard
    input  wire logic                      i_watch_match,
    output logic                           o_watch_hit,
    input  wire logic                      i_hb_jump,
    output logic                           o_fetch_hold
);
    import mbs_pkg::*;

    mbs_state_t          state_ff;
    mbs_state_t          nxt_state;
    logic [OUTS_W-1:0]   cnt_ff;
    logic [OUTS_W-1:0]   nxt_cnt;
    logic [ADDR_W-1:0]   va_ff;
    logic [ADDR_W-1:0]   nxt_va;
    logic                ready_ff;
    logic                done_ff;
    logic                nxt_done;
    logic                exc_ff;
    logic                nxt_exc;
    logic [EXC_W-1:0]    code_ff;
    logic [EXC_W-1:0]    nxt_code;
    logic                cerr_ff;
    logic                nxt_cerr;
    logic                watch_ff;
    logic                nxt_watch;
    logic                hold_ff;
    logic                fhold_ff;
    logic                nxt_fhold;
    logic                xreq_ff;
    logic                lreq_ff;
    logic                lock_ff;

    wire logic [ADDR_W-1:0] ea;
    wire logic              take;
    wire logic              take_bar;
    wire logic              take_line;
    wire logic              mem_sync;
    wire logic              inc;
    wire logic              dec;
    wire logic              drained;
    wire logic              line_busy;
    wire logic              xlat_fault;
    wire logic              kfault;
    wire logic              line_fin;

    mbs_ea_add #(
        .OFF_W  (OFF_W),
        .ADDR_W (ADDR_W)
    ) u_ea (
        .i_offset (i_offset),
        .i_base   (i_base),
        .o_ea     (ea)
    );

    // Issue decode; barrier type field is not examined
    assign take      = i_op_valid && ready_ff;
    assign take_bar  = take && (i_op_kind == MBS_OP_BARRIER);
    assign take_line = take && (i_op_kind == MBS_OP_LINE);

    // Only uncached or coherent, non-prefetch accesses are tracked
    assign mem_sync  = (i_mem_cca == CCA_UNCACHED)
                    || (i_mem_cca == CCA_COHERENT);
    assign inc       = i_mem_issue && mem_sync
                    && !i_mem_prefetch;
    // Retire only when globally performed, loads and stores alike
    assign dec       = i_mem_gperf && (cnt_ff != OUTS_RST);
    assign drained   = (cnt_ff == OUTS_RST);

    assign line_busy  = (state_ff == ST_XLAT) || (state_ff == ST_LINE);
    assign xlat_fault = i_xlat_refill || i_xlat_invalid;
    assign kfault     = i_xlat_kfault && KSEG_ADDR_ERR;
    assign line_fin   = (state_ff == ST_LINE) && i_line_ack;

    // Mixed-type hazards and writeback buffers get no special handling
    assign nxt_cnt = cnt_ff + OUTS_W'(inc) - OUTS_W'(dec);

    // Fetch held after hazard jump until line sync completes
    assign nxt_fhold = (i_hb_jump || fhold_ff) && line_busy
                    && (nxt_state != ST_IDLE);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_va    = va_ff;
        nxt_done  = 1'b0;
        nxt_exc   = 1'b0;
        nxt_code  = EXC_NONE;
        nxt_cerr  = 1'b0;
        nxt_watch = 1'b0;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (take_line && i_arch_rel1)
                begin
                    nxt_done = 1'b1;
                    nxt_exc  = 1'b1;
                    nxt_code = EXC_RSVD;
                end
                else if (take_line)
                begin
                    nxt_state = ST_XLAT;
                    nxt_va    = ea;
                end
                else if (take_bar && (i_strong_order || drained))
                begin
                    nxt_done = 1'b1;
                end
                else if (take_bar)
                begin
                    nxt_state = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                if (drained)
                begin
                    nxt_state = ST_IDLE;
                    nxt_done  = 1'b1;
                end
            end
            ST_XLAT:
            begin
                if (i_xlat_ack && xlat_fault)
                begin
                    nxt_state = ST_IDLE;
                    nxt_done  = 1'b1;
                    nxt_exc   = 1'b1;
                    nxt_code  = EXC_XLAT_LD;
                end
                else if (i_xlat_ack && kfault)
                begin
                    nxt_state = ST_IDLE;
                    nxt_done  = 1'b1;
                    nxt_exc   = 1'b1;
                    nxt_code  = EXC_ADDR_LD;
                end
                else if (i_xlat_ack)
                begin
                    nxt_state = ST_LINE;
                    nxt_watch = WATCH_ON_LINE && i_watch_match;
                end
            end
            ST_LINE:
            begin
                if (i_line_ack)
                begin
                    nxt_state = ST_IDLE;
                    nxt_done  = 1'b1;
                    if (i_line_err)
                    begin
                        nxt_exc  = 1'b1;
                        nxt_cerr = 1'b1;
                        nxt_code = EXC_CACHE;
                    end
                    else if (i_line_bus_err)
                    begin
                        nxt_exc  = 1'b1;
                        nxt_code = EXC_BUS_DATA;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            state_ff <= ST_IDLE;
            cnt_ff   <= OUTS_RST;
            va_ff    <= ADDR_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            va_ff    <= nxt_va;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            ready_ff <= 1'b0;
            done_ff  <= 1'b0;
            exc_ff   <= 1'b0;
            code_ff  <= EXC_NONE;
            cerr_ff  <= 1'b0;
            watch_ff <= 1'b0;
            hold_ff  <= 1'b0;
            fhold_ff <= 1'b0;
            xreq_ff  <= 1'b0;
            lreq_ff  <= 1'b0;
            lock_ff  <= 1'b0;
        end
        else
        begin
            ready_ff <= (nxt_state == ST_IDLE);
            done_ff  <= nxt_done;
            exc_ff   <= nxt_exc;
            code_ff  <= nxt_code;
            cerr_ff  <= nxt_cerr;
            watch_ff <= nxt_watch;
            hold_ff  <= (nxt_state == ST_DRAIN);
            fhold_ff <= nxt_fhold;
            xreq_ff  <= (nxt_state == ST_XLAT);
            lreq_ff  <= (nxt_state == ST_LINE);
            lock_ff  <= (nxt_state == ST_XLAT) || (nxt_state == ST_LINE);
        end
    end

    assign o_op_ready          = ready_ff;
    assign o_op_done           = done_ff;
    assign o_exc_valid         = exc_ff;
    assign o_exc_code          = code_ff;
    assign o_cache_err         = cerr_ff;
    assign o_mem_hold          = hold_ff;
    assign o_watch_hit         = watch_ff;
    assign o_fetch_hold        = fhold_ff;
    assign o_xlat_va           = va_ff;
    // Request levels registered alongside state
    assign o_xlat_req          = xreq_ff;
    assign o_line_req          = lreq_ff;
    // Line address rounds down to the one containing line
    assign o_line_addr         = {va_ff[ADDR_W-1:LINE_OFS_W],
                                  {LINE_OFS_W{1'b0}}};
    assign o_line_spare_locked = lock_ff;

    logic past_valid_ff;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
            past_valid_ff <= 1'b0;
        else
            past_valid_ff <= 1'b1;
    end

    property p_drain_done;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (state_ff == ST_DRAIN && drained) |=> (o_op_done && !o_mem_hold);
    endproperty
    a_drain_done: assert property (p_drain_done)
        else $error("barrier did not finish after drain");

    property p_hold_drain;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (take_bar && !i_strong_order && !drained)
            |=> (o_mem_hold throughout (state_ff == ST_DRAIN));
    endproperty
    a_hold_drain: assert property (p_hold_drain)
        else $error("later accesses not held during drain");

    property p_strong_nop;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (take_bar && i_strong_order) |=> (o_op_done && !o_exc_valid);
    endproperty
    a_strong_nop: assert property (p_strong_nop)
        else $error("strongly ordered barrier not immediate");

    property p_rel1_rsvd;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (take_line && i_arch_rel1)
            |=> (o_exc_valid && o_exc_code == EXC_RSVD && o_op_ready);
    endproperty
    a_rel1_rsvd: assert property (p_rel1_rsvd)
        else $error("release 1 line sync not reserved");

    property p_no_store_cause;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_exc_valid |-> (o_exc_code != EXC_XLAT_ST);
    endproperty
    a_no_store_cause: assert property (p_no_store_cause)
        else $error("store-cause exception from line sync");

    property p_ea_latch;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (take_line && !i_arch_rel1)
            |=> (o_xlat_req && o_xlat_va == $past(i_base)
                 + {{(ADDR_W-OFF_W){$past(i_offset[OFF_W-1])}},
                    $past(i_offset)});
    endproperty
    a_ea_latch: assert property (p_ea_latch)
        else $error("effective address wrong");

    property p_line_one;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_line_req |-> (o_line_addr[ADDR_W-1:LINE_OFS_W]
                        == o_xlat_va[ADDR_W-1:LINE_OFS_W]
                        && o_line_addr[LINE_OFS_W-1:0] == '0);
    endproperty
    a_line_one: assert property (p_line_one)
        else $error("line address not the containing line");

    property p_cache_err;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (state_ff == ST_LINE && i_line_ack && i_line_err)
            |=> (o_cache_err && o_exc_code == EXC_CACHE)
            ##1 (!o_cache_err && o_op_ready);
    endproperty
    a_cache_err: assert property (p_cache_err)
        else $error("writeback error not reported");

    property p_fetch_hold;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_hb_jump && line_busy && !line_fin)
            |=> (o_fetch_hold until o_op_done);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold)
        else $error("fetch resumed before line sync done");

    property p_nonsync_ignored;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (past_valid_ff && i_mem_issue && !mem_sync && !i_mem_gperf)
            |=> (cnt_ff == $past(cnt_ff));
    endproperty
    a_nonsync_ignored: assert property (p_nonsync_ignored)
        else $error("non-synchronizable access counted");

    property p_locked_spared;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_line_req |-> o_line_spare_locked;
    endproperty
    a_locked_spared: assert property (p_locked_spared)
        else $error("line op may disturb locked lines");

    c_drain: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (state_ff == ST_DRAIN) ##[1:20] o_op_done);
    c_line_ok: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        line_fin && !i_line_err && !i_line_bus_err);
    c_xlat_fault: cover property (@(posedge i_core_clk)
        disable iff (!i_reset_n)
        o_exc_valid && o_exc_code == EXC_XLAT_LD);
    c_hb_hold: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        o_fetch_hold ##[1:20] !o_fetch_hold);

endmodule : mbs_barrier_sync

/* mbs_ea_add.sv */
// Effective address: sign-extended offset plus base
`timescale 1ns/100ps
module mbs_ea_add #(
    parameter int OFF_W  = 16,
    parameter int ADDR_W = 32
) (
    // Operands
    input  wire logic [OFF_W-1:0]  i_offset,
    input  wire logic [ADDR_W-1:0] i_base,
    // Result
    output wire logic [ADDR_W-1:0] o_ea
);
    wire logic [ADDR_W-1:0] offset_sx;

    assign offset_sx = {{(ADDR_W-OFF_W){i_offset[OFF_W-1]}}, i_offset};
    assign o_ea      = i_base + offset_sx;
endmodule : mbs_ea_add

/* mbs_mem_partner.sv */
// Memory-system partner: translation, line ops, global completion
`timescale 1ns/100ps
module mbs_mem_partner (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    // Bench knobs
    input  wire logic [3:0] i_lat,
    input  wire logic [2:0] i_xfault,
    input  wire logic [1:0] i_lfault,
    // Core side
    input  wire logic       i_mem_issue,
    input  wire logic [2:0] i_mem_cca,
    input  wire logic       i_mem_prefetch,
    input  wire logic       i_xlat_req,
    input  wire logic       i_line_req,
    // Answers
    output logic            o_mem_gperf,
    output logic            o_xlat_ack,
    output logic [2:0]      o_xlat_flt,
    output logic            o_line_ack,
    output logic [1:0]      o_line_flt,
    output int              o_pending
);
    import mbs_pkg::*;
    int   gw  = 0;
    int   xw  = 0;
    int   lw  = 0;
    logic tog = 1'b0;
    logic trk;
    logic xgo;
    logic lgo;

    assign trk = i_mem_issue && !i_mem_prefetch
                 && (i_mem_cca == CCA_UNCACHED || i_mem_cca == CCA_COHERENT);
    assign xgo = i_xlat_req && !o_xlat_ack && xw >= int'(i_lat);
    assign lgo = i_line_req && !o_line_ack && lw >= int'(i_lat);

    always @(posedge i_core_clk)
        if (!i_reset_n)
            o_pending <= 0;
        else
            o_pending <= o_pending + int'(trk) - int'(o_mem_gperf);

    // Coherent agents complete tracked accesses one at a time
    always @(negedge i_core_clk)
    begin
        tog         <= !tog;
        o_mem_gperf <= o_pending > 0 && gw >= int'(i_lat);
        gw          <= (o_pending > 0 && gw < int'(i_lat)) ? gw + 1 : 0;
        o_xlat_ack  <= xgo;
        xw          <= (i_xlat_req && !xgo) ? xw + 1 : 0;
        o_line_ack  <= lgo;
        lw          <= (i_line_req && !lgo) ? lw + 1 : 0;
        // Qualifiers carry no meaning outside an answer
        o_xlat_flt  <= xgo ? i_xfault : {3{tog}};
        o_line_flt  <= lgo ? i_lfault : {2{tog}};
    end
endmodule : mbs_mem_partner

/* mbs_pkg.sv */
// Shared constants and types for the barrier and line-sync block
package mbs_pkg;

    localparam int ADDR_W     = 32;
    localparam int OFF_W      = 16;
    localparam int STYPE_W    = 5;
    localparam int CCA_W      = 3;
    localparam int OUTS_W     = 4;
    localparam int LINE_OFS_W = 5;
    localparam int EXC_W      = 5;

    localparam logic [CCA_W-1:0]   CCA_UNCACHED = 3'h2;
    localparam logic [CCA_W-1:0]   CCA_COHERENT = 3'h5;
    localparam logic [STYPE_W-1:0] STYPE_FULL   = 5'h00;

    localparam logic [EXC_W-1:0] EXC_NONE     = 5'h00;
    localparam logic [EXC_W-1:0] EXC_XLAT_LD  = 5'h02;
    localparam logic [EXC_W-1:0] EXC_XLAT_ST  = 5'h03;
    localparam logic [EXC_W-1:0] EXC_ADDR_LD  = 5'h04;
    localparam logic [EXC_W-1:0] EXC_BUS_DATA = 5'h07;
    localparam logic [EXC_W-1:0] EXC_RSVD     = 5'h0A;
    localparam logic [EXC_W-1:0] EXC_CACHE    = 5'h1E;

    localparam logic WATCH_ON_LINE = 1'b0;
    localparam logic KSEG_ADDR_ERR = 1'b1;

    localparam logic [OUTS_W-1:0] OUTS_RST = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        MBS_OP_NONE,
        MBS_OP_BARRIER,
        MBS_OP_LINE
    } mbs_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DRAIN,
        ST_XLAT,
        ST_LINE
    } mbs_state_t;

endpackage : mbs_pkg

/* memory_barrier_and_icache_sync_bench.sv */
// Self-checking bench for the barrier and line-sync block
`timescale 1ns/100ps
module memory_barrier_and_icache_sync_bench;
    import mbs_pkg::*;
    logic               i_core_clk     = 1'b0;
    logic               i_reset_n      = 1'b0;
    logic               i_op_valid     = 1'b0;
    mbs_op_t            i_op_kind      = MBS_OP_NONE;
    logic [STYPE_W-1:0] i_stype        = STYPE_FULL;
    logic [ADDR_W-1:0]  i_base         = '0;
    logic [OFF_W-1:0]   i_offset       = '0;
    logic               i_arch_rel1    = 1'b0;
    logic               i_strong_order = 1'b0;
    logic               i_mem_issue    = 1'b0;
    logic [CCA_W-1:0]   i_mem_cca      = '0;
    logic               i_mem_prefetch = 1'b0;
    logic               i_watch_match  = 1'b0;
    logic               i_hb_jump      = 1'b0;
    logic [3:0]         lat            = 4'h0;
    logic [2:0]         xfault         = 3'h0;
    logic [1:0]         lfault         = 2'h0;
    logic               o_op_ready, o_op_done, o_exc_valid, o_cache_err;
    logic               o_mem_hold, o_xlat_req, o_line_req, o_fetch_hold;
    logic               o_line_spare_locked, o_watch_hit;
    logic [EXC_W-1:0]   o_exc_code;
    logic [ADDR_W-1:0]  o_xlat_va, o_line_addr;
    logic               gperf, xack, lack;
    logic [2:0]         xflt;
    logic [1:0]         lflt;
    int                 pending;
    int                 fail_count = 0;
    int                 checks     = 0;
    int                 seed       = 5868;
    logic [31:0]        cb [3] = '{32'hFFFF_FFF0, 32'h0000_1000, 32'h7FFF_FFE1};
    logic [15:0]        co [3] = '{16'h0020, 16'h8000, 16'h7FFF};

    always #2 i_core_clk = !i_core_clk;

    mbs_barrier_sync i_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_op_valid(i_op_valid), .i_op_kind(i_op_kind), .i_stype(i_stype),
        .i_base(i_base), .i_offset(i_offset), .i_arch_rel1(i_arch_rel1),
        .i_strong_order(i_strong_order), .o_op_ready(o_op_ready),
        .o_op_done(o_op_done), .o_exc_valid(o_exc_valid),
        .o_exc_code(o_exc_code), .o_cache_err(o_cache_err),
        .i_mem_issue(i_mem_issue), .i_mem_cca(i_mem_cca),
        .i_mem_prefetch(i_mem_prefetch), .i_mem_gperf(gperf),
        .o_mem_hold(o_mem_hold), .o_xlat_req(o_xlat_req),
        .o_xlat_va(o_xlat_va), .i_xlat_ack(xack), .i_xlat_refill(xflt[0]),
        .i_xlat_invalid(xflt[1]), .i_xlat_kfault(xflt[2]),
        .o_line_req(o_line_req), .o_line_addr(o_line_addr),
        .o_line_spare_locked(o_line_spare_locked), .i_line_ack(lack),
        .i_line_err(lflt[0]), .i_line_bus_err(lflt[1]),
        .i_watch_match(i_watch_match), .o_watch_hit(o_watch_hit),
        .i_hb_jump(i_hb_jump), .o_fetch_hold(o_fetch_hold));

    mbs_mem_partner i_mem (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_lat(lat), .i_xfault(xfault), .i_lfault(lfault),
        .i_mem_issue(i_mem_issue), .i_mem_cca(i_mem_cca),
        .i_mem_prefetch(i_mem_prefetch), .i_xlat_req(o_xlat_req),
        .i_line_req(o_line_req), .o_mem_gperf(gperf), .o_xlat_ack(xack),
        .o_xlat_flt(xflt), .o_line_ack(lack), .o_line_flt(lflt),
        .o_pending(pending));

    task automatic finish_test();
        if (fail_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic check(input string nm, input logic [31:0] ex,
                         input logic [31:0] got);
        checks++;
        if (got !== ex)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : check

    function automatic logic [31:0] exp_ea(input logic [31:0] b,
                                           input logic [15:0] o);
        return b + {{16{o[15]}}, o};
    endfunction : exp_ea

    function automatic logic [4:0] exp_code(input mbs_op_t k, input logic r1);
        if (k != MBS_OP_LINE) return EXC_NONE;
        if (r1) return EXC_RSVD;
        if (xfault[1:0] != 2'b00) return EXC_XLAT_LD;
        if (xfault[2] && KSEG_ADDR_ERR) return EXC_ADDR_LD;
        if (lfault[0]) return EXC_CACHE;
        if (lfault[1]) return EXC_BUS_DATA;
        return EXC_NONE;
    endfunction : exp_code

    // Core loads and stores ahead of an op; untr keeps them untracked
    task automatic issue(input int n, input logic untr);
        repeat (n)
        begin
            @(negedge i_core_clk);
            i_mem_issue    = pending < 12 && ($random(seed) & 1);
            i_mem_cca      = ($random(seed) & 1) ? CCA_COHERENT
                                                 : 3'($random(seed));
            i_mem_prefetch = untr ? (i_mem_cca == CCA_COHERENT
                                     || i_mem_cca == CCA_UNCACHED)
                                  : (($random(seed) & 3) == 0);
        end
        @(negedge i_core_clk);
        i_mem_issue = 1'b0;
    endtask : issue

    task automatic run_op(input mbs_op_t k, input logic [31:0] b,
                          input logic [15:0] o, input logic hb);
        logic [4:0] code;
        logic       held;
        int         n;
        int         p0;
        code = exp_code(k, i_arch_rel1);
        held = 1'b0;
        n    = 1;
        p0   = pending;
        check("op_ready", 1, o_op_ready);
        i_op_kind  = k;
        i_base     = b;
        i_offset   = o;
        i_op_valid = 1'b1;
        @(negedge i_core_clk);
        i_op_valid = 1'b0;
        i_hb_jump  = hb;
        while (o_op_done !== 1'b1 && n < 400)
        begin
            if (k == MBS_OP_BARRIER)
                check("mem_hold", 1, o_mem_hold);
            if (o_xlat_req === 1'b1)
                check("xlat_va", exp_ea(b, o), o_xlat_va);
            if (o_line_req === 1'b1)
            begin
                check("line_addr", exp_ea(b, o) & 32'hFFFF_FFE0,
                      o_line_addr);
                check("spare_locked", 1, o_line_spare_locked);
            end
            check("watch_hit", 0, o_watch_hit);
            held |= (o_fetch_hold === 1'b1);
            // A request while busy must be refused
            i_op_valid = (n == 2);
            @(negedge i_core_clk);
            i_hb_jump = 1'b0;
            n++;
        end
        i_op_valid = 1'b0;
        check("op_done", 1, o_op_done);
        if (o_op_done !== 1'b1)
            finish_test();
        check("exc_valid", |code, o_exc_valid);
        check("exc_code", code, o_exc_code);
        check("cache_err", code == EXC_CACHE, o_cache_err);
        check("op_ready", 1, o_op_ready);
        if (k == MBS_OP_BARRIER && !i_strong_order)
            check("pending", 0, pending);
        if (k == MBS_OP_BARRIER && (i_strong_order || p0 == 0))
            check("latency", 1, n);
        if (k == MBS_OP_LINE && i_arch_rel1)
            check("latency", 1, n);
        // A jump during translation holds fetch unless the fault ends it
        check("hold_seen", hb && k == MBS_OP_LINE && code != EXC_RSVD
              && !(lat == 4'h0 && (code == EXC_XLAT_LD
              || code == EXC_ADDR_LD)), held);
        @(negedge i_core_clk);
        check("fetch_hold", 0, o_fetch_hold);
        check("mem_hold", 0, o_mem_hold);
        check("extra_done", 0, o_op_done);
    endtask : run_op

    initial
    begin
        logic [31:0] b;
        logic [15:0] o;
        mbs_op_t     k;
        repeat (6) @(negedge i_core_clk);
        i_reset_n = 1'b1;
        repeat (3) @(negedge i_core_clk);
        for (int i = 0; i < 80; i++)
        begin
            lat            = 4'($random(seed));
            xfault         = ($random(seed) & 3) ? 3'h0 : 3'($random(seed));
            lfault         = ($random(seed) & 3) ? 2'h0 : 2'($random(seed));
            i_arch_rel1    = ($random(seed) & 7) == 0;
            i_strong_order = ($random(seed) & 3) == 0;
            i_watch_match  = 1'($random(seed));
            i_stype        = STYPE_FULL;
            b              = $random(seed);
            o              = 16'($random(seed));
            k              = ($random(seed) & 1) ? MBS_OP_LINE
                                                 : MBS_OP_BARRIER;
            if (i < 3)
            begin
                b           = cb[i];
                o           = co[i];
                k           = MBS_OP_LINE;
                xfault      = 3'h0;
                i_arch_rel1 = 1'b0;
            end
            if (i == 3 || i == 7)
            begin
                k              = MBS_OP_BARRIER;
                i_strong_order = 1'b0;
            end
            issue(6 + i % 3 * 4, i == 3 || i == 7);
            run_op(k, b, o, 1'($random(seed)));
        end
        finish_test();
    end
endmodule : memory_barrier_and_icache_sync_bench
